// ### bps_supervisor.sv
// Digital supervisor of a three-cell battery protector: scan, trip, sleep, serial port.
// Assumes comparator results and serial pins are synchronous to ref_clk_i.
`timescale 1ns/1ps
module bps_supervisor #(
  parameter logic [15:0] SCAN_CYC = 16'(bps_pkg::SCAN_CYC_DEF),
  parameter int NV_WRITE_CYC = bps_pkg::NV_WRITE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire bps_pkg::bps_spi_t spi_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  input wire logic cell_ov_cmp_i,
  input wire logic cell_uv_cmp_i,
  input wire logic overcurrent_i,
  input wire logic load_release_i,
  input wire logic wake_i,
  input wire logic [bps_pkg::SRC_W-1:0] analog_select_inputs_i,
  output logic [bps_pkg::CELL_IDX_W-1:0] cell_sel_o,
  output bps_pkg::bps_drive_t drive_o,
  output bps_pkg::bps_mon_t mon_o,
  output logic sleep_o
);
  import bps_pkg::*;

  bps_state_t s_reg;
  bps_state_t s_next;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic scan_tick;
  logic nv_busy;
  logic [NV_DATA_W-1:0] nv_rd_data;
  logic [7:0] status_byte;

  function automatic logic [CELL_IDX_W-1:0] next_cell(input logic [CELL_IDX_W-1:0] idx);
    next_cell = (idx == CELL_IDX_W'(CELL_N - 1)) ? '0 : idx + CELL_IDX_W'(1);
  endfunction

  // Drive levels: low turns the switch on, so any trip or sleep forces high
  function automatic bps_drive_t drive_of(input bps_state_t s);
    bps_drive_t d;
    d.discharge_drive_out = ~s.ctrl[CTRL_DIS_BIT] | s.oc_trip;
    d.charge_drive_load_sense = ~s.ctrl[CTRL_CHG_BIT] | (|s.ov_trip);
    d.cell_balance_drive = s.ctrl[CTRL_BAL_LSB +: BAL_N];
    d.regulator_control_out = (s.mode == BPS_NORMAL);
    return d;
  endfunction

  // ==========================================================
  // Edge detection on the serial pins
  assign sck_rise = spi_i.sck & ~s_reg.sck_q & ~spi_i.cs_b;
  assign sck_fall = ~spi_i.sck & s_reg.sck_q & ~spi_i.cs_b;
  assign cs_rise = spi_i.cs_b & ~s_reg.cs_b_q;
  assign scan_tick = (s_reg.scan_cnt == SCAN_CYC - 16'h0001);

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_BUSY] = nv_busy;
    status_byte[ST_WEL] = s_reg.wel;
    status_byte[ST_OC] = s_reg.oc_trip;
    status_byte[ST_OV] = |s_reg.ov_trip;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.ee_req = 1'b0;
    s_next.sck_q = spi_i.sck;
    s_next.cs_b_q = spi_i.cs_b;

    if (s_reg.mode == BPS_NORMAL) begin
      // Periodic cell scan; the analog side follows cell_sel_o
      if (scan_tick) begin
        s_next.scan_cnt = '0;
        s_next.ov_trip[s_reg.cell_idx] = cell_ov_cmp_i;
        s_next.cell_idx = next_cell(s_reg.cell_idx);
      end else begin
        s_next.scan_cnt = s_reg.scan_cnt + 16'h0001;
      end

      // Set wins over release, so a fresh fault is never dropped
      if (overcurrent_i) begin
        s_next.oc_trip = 1'b1;
      end else if (load_release_i) begin
        s_next.oc_trip = 1'b0;
      end

      // Monitor path only steers the analog mux, never the detectors
      s_next.mon.src = analog_select_inputs_i;
      s_next.mon.gain = s_reg.ctrl[CTRL_GAIN_LSB +: GAIN_W];

      // Serial receive on rising clock
      if (spi_i.cs_b) begin
        s_next.bit_cnt = '0;
        s_next.so_oe = 1'b0;
      end else begin
        s_next.so_oe = 1'b1;
      end
      if (sck_rise) begin
        s_next.rx = {s_reg.rx[30:0], spi_i.si};
        if (s_reg.bit_cnt != CNT_NV_FULL) begin
          s_next.bit_cnt = s_reg.bit_cnt + BIT_W'(1);
        end
        if (s_reg.bit_cnt == CNT_OP - BIT_W'(1)) begin
          s_next.op = {s_reg.rx[6:0], spi_i.si};
        end
      end

      // Serial transmit on falling clock
      if (sck_fall) begin
        if (s_reg.bit_cnt == CNT_OP && s_reg.op == OP_STATUS_READ) begin
          s_next.so = status_byte[7];
          s_next.tx = {status_byte[6:0], 1'b0};
        end else if (s_reg.bit_cnt == CNT_NV_ADDR && s_reg.op == OP_NV_READ) begin
          s_next.so = nv_rd_data[7];
          s_next.tx = {nv_rd_data[6:0], 1'b0};
        end else begin
          s_next.so = s_reg.tx[7];
          s_next.tx = {s_reg.tx[6:0], 1'b0};
        end
      end

      // Commands take effect when chip select rises on a whole frame
      if (cs_rise) begin
        if (s_reg.op == OP_WR_ENABLE && s_reg.bit_cnt == CNT_OP) begin
          s_next.wel = 1'b1;
        end else if (s_reg.op == OP_WR_DISABLE && s_reg.bit_cnt == CNT_OP) begin
          s_next.wel = 1'b0;
        end else if (s_reg.op == OP_CTRL_WRITE && s_reg.bit_cnt == CNT_CTRL) begin
          s_next.ctrl = s_reg.rx[CTRL_W-1:0];
        end else if (s_reg.op == OP_NV_WRITE && s_reg.bit_cnt == CNT_NV_FULL) begin
          if (s_reg.wel && !nv_busy) begin
            s_next.ee_req = 1'b1;
            s_next.wel = 1'b0;
          end
        end
      end

      // Over-discharge: drop everything and sleep
      if (scan_tick && cell_uv_cmp_i) begin
        s_next.mode = BPS_SLEEP;
        s_next.ctrl = CTRL_RESET;
        s_next.so_oe = 1'b0;
        s_next.wel = 1'b0;
      end
    end else begin
      // Sleep: host is unpowered, serial port is ignored
      s_next.so_oe = 1'b0;
      s_next.bit_cnt = '0;
      if (wake_i) begin
        s_next = '0;
        s_next.mode = BPS_NORMAL;
        s_next.ctrl = CTRL_RESET;
        s_next.sck_q = spi_i.sck;
        s_next.cs_b_q = spi_i.cs_b;
      end
    end

    // Registered drives track the next state: one cycle, well under CO_CYC
    s_next.drv = drive_of(s_next);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.cs_b_q <= 1'b1;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.drv.discharge_drive_out <= 1'b1;
      s_reg.drv.charge_drive_load_sense <= 1'b1;
      s_reg.drv.regulator_control_out <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Nonvolatile store
  bps_nv_store #(
    .ADDR_W(NV_ADDR_W),
    .DATA_W(NV_DATA_W),
    .WRITE_CYC(NV_WRITE_CYC)
  ) u_nv (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .wr_req_i(s_reg.ee_req),
    .wr_addr_i(s_reg.rx[8 +: NV_ADDR_W]),
    .wr_data_i(s_reg.rx[NV_DATA_W-1:0]),
    .rd_addr_i(s_reg.rx[NV_ADDR_W-1:0]),
    .rd_data_o(nv_rd_data),
    .busy_o(nv_busy)
  );

  assign spi_so_o = s_reg.so;
  assign spi_so_oe_o = s_reg.so_oe;
  assign cell_sel_o = s_reg.cell_idx;
  assign drive_o = s_reg.drv;
  assign mon_o = s_reg.mon;
  assign sleep_o = (s_reg.mode == BPS_SLEEP);

  // ==========================================================
  // Checks
  property p_scan_step;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (s_reg.mode == BPS_NORMAL && scan_tick && !cell_uv_cmp_i)
        |=> cell_sel_o == next_cell($past(cell_sel_o));
  endproperty
  a_scan_step: assert property (p_scan_step)
    else $error("cell scan did not advance");

  property p_oc_trip;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (s_reg.mode == BPS_NORMAL && overcurrent_i) |=> drive_o.discharge_drive_out;
  endproperty
  a_oc_trip: assert property (p_oc_trip)
    else $error("overcurrent left discharge drive on");

  property p_ov_trip;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (|s_reg.ov_trip) |-> drive_o.charge_drive_load_sense;
  endproperty
  a_ov_trip: assert property (p_ov_trip)
    else $error("over-charge left charge drive on");

  property p_uv_sleep;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (s_reg.mode == BPS_NORMAL && scan_tick && cell_uv_cmp_i)
        |=> sleep_o && !drive_o.regulator_control_out && drive_o.discharge_drive_out;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep)
    else $error("over-discharge did not enter sleep");

  property p_monitor_prot;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (s_reg.mode == BPS_NORMAL && analog_select_inputs_i != '0 && overcurrent_i)
        |=> s_reg.oc_trip;
  endproperty
  a_monitor_prot: assert property (p_monitor_prot)
    else $error("monitor selection blocked protection");

  property p_ctrl_follow;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $changed(s_reg.ctrl) |-> drive_o.cell_balance_drive == s_reg.ctrl[CTRL_BAL_LSB +: BAL_N];
  endproperty
  a_ctrl_follow: assert property (p_ctrl_follow)
    else $error("drives lag the control register");

  property p_drive_on;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (s_reg.ctrl[CTRL_DIS_BIT] && !s_reg.oc_trip) |-> !drive_o.discharge_drive_out;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("discharge drive not low when enabled");

  property p_bal_cmd;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ($changed(drive_o.cell_balance_drive) && !$past(sleep_o) && !sleep_o)
        |-> $past(cs_rise) && $past(s_reg.op) == OP_CTRL_WRITE;
  endproperty
  a_bal_cmd: assert property (p_bal_cmd)
    else $error("balance drive changed without a command");

  property p_wake_clear;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sleep_o && wake_i) |=> s_reg.ctrl == CTRL_RESET ##0 drive_o.charge_drive_load_sense
        ##0 drive_o.discharge_drive_out;
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake left control bits set");

  property p_nv_gate;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (s_reg.mode == BPS_NORMAL && cs_rise && s_reg.op == OP_NV_WRITE
        && s_reg.bit_cnt == CNT_NV_FULL && nv_busy) |=> !s_reg.ee_req;
  endproperty
  a_nv_gate: assert property (p_nv_gate)
    else $error("write accepted during a busy cycle");

  property p_nv_start;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      s_reg.ee_req |=> nv_busy;
  endproperty
  a_nv_start: assert property (p_nv_start)
    else $error("write request did not start the cycle");

  property p_sleep_quiet;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      sleep_o |-> (!spi_so_oe_o && !drive_o.regulator_control_out);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("sleep left regulator or serial output on");

endmodule

// ### bps_pkg.sv
// Shared constants and carrier types for the battery protection supervisor.
// Assumes a single 125 MHz clock; all pin inputs arrive synchronous to it.
package bps_pkg;

  // ==========================================================
  // Geometry
  localparam int CELL_N = 3;
  localparam int BAL_N = 4;
  localparam int CELL_IDX_W = 2;
  localparam int SCAN_W = 16;
  localparam int GAIN_W = 2;
  localparam int SRC_W = 3;

  // ==========================================================
  // Control register layout
  localparam int CTRL_W = 16;
  localparam int CTRL_DIS_BIT = 0;
  localparam int CTRL_CHG_BIT = 1;
  localparam int CTRL_BAL_LSB = 2;
  localparam int CTRL_GAIN_LSB = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  // ==========================================================
  // Serial port commands and frame lengths
  localparam logic [7:0] OP_CTRL_WRITE = 8'h01;
  localparam logic [7:0] OP_NV_WRITE = 8'h02;
  localparam logic [7:0] OP_NV_READ = 8'h03;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam int BIT_W = 6;
  localparam logic [BIT_W-1:0] CNT_OP = 6'h08;
  localparam logic [BIT_W-1:0] CNT_CTRL = 6'h18;
  localparam logic [BIT_W-1:0] CNT_NV_ADDR = 6'h18;
  localparam logic [BIT_W-1:0] CNT_NV_FULL = 6'h20;

  // ==========================================================
  // Status byte bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_WEL = 6;
  localparam int ST_OC = 5;
  localparam int ST_OV = 4;

  // ==========================================================
  // Nonvolatile user memory, 4 kbit as 512 bytes
  localparam int NV_ADDR_W = 9;
  localparam int NV_DATA_W = 8;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int NV_WRITE_TIME_MS = 5;
  localparam int NV_WRITE_CYC = NV_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CO_TIME_NS = 1000;
  localparam int CO_CYC = CO_TIME_NS / CLK_PERIOD_NS;
  localparam int SCAN_CYC_DEF = 1024;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    BPS_NORMAL = 2'b00,
    BPS_SLEEP = 2'b01
  } bps_mode_t;

  typedef struct packed {
    logic sck;
    logic cs_b;
    logic si;
  } bps_spi_t;

  typedef struct packed {
    logic discharge_drive_out;
    logic charge_drive_load_sense;
    logic [BAL_N-1:0] cell_balance_drive;
    logic regulator_control_out;
  } bps_drive_t;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [SRC_W-1:0] src;
  } bps_mon_t;

  typedef struct packed {
    bps_mode_t mode;
    logic [CTRL_W-1:0] ctrl;
    logic [CELL_N-1:0] ov_trip;
    logic oc_trip;
    logic [CELL_IDX_W-1:0] cell_idx;
    logic [SCAN_W-1:0] scan_cnt;
    logic sck_q;
    logic cs_b_q;
    logic [BIT_W-1:0] bit_cnt;
    logic [7:0] op;
    logic [31:0] rx;
    logic [7:0] tx;
    logic wel;
    logic so;
    logic so_oe;
    logic ee_req;
    bps_drive_t drv;
    bps_mon_t mon;
  } bps_state_t;

endpackage

// ### bps_nv_store.sv
// Nonvolatile user memory with a self-timed write cycle.
// Assumes writes are requested by one-cycle pulses from the supervisor.
`timescale 1ns/1ps
module bps_nv_store #(
  parameter int ADDR_W = bps_pkg::NV_ADDR_W,
  parameter int DATA_W = bps_pkg::NV_DATA_W,
  parameter int WRITE_CYC = bps_pkg::NV_WRITE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wr_req_i,
  input wire logic [ADDR_W-1:0] wr_addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic busy_o
);
  import bps_pkg::*;

  localparam int CNT_W = $clog2(WRITE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYC - 1);

  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] rd_data;
  } bps_nv_state_t;

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  bps_nv_state_t s_reg;
  bps_nv_state_t s_next;
  logic accept;

  // ==========================================================
  // Write cycle timer
  assign accept = wr_req_i & ~s_reg.busy;

  always_comb begin
    s_next = s_reg;
    s_next.rd_data = mem[rd_addr_i];
    if (accept) begin
      s_next.busy = 1'b1;
      s_next.cnt = CNT_LOAD;
    end else if (s_reg.busy) begin
      if (s_reg.cnt == '0) begin
        s_next.busy = 1'b0;
      end else begin
        s_next.cnt = s_reg.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Array content survives reset, as a nonvolatile store should
  always_ff @(posedge ref_clk_i) begin
    if (accept) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = s_reg.rd_data;
  assign busy_o = s_reg.busy;

  // ==========================================================
  // Checks
  property p_nv_load;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      accept |=> (busy_o && s_reg.cnt == CNT_LOAD);
  endproperty
  a_nv_load: assert property (p_nv_load)
    else $error("write cycle did not start with the full count");

  property p_nv_end;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (busy_o && s_reg.cnt == '0 && !wr_req_i) |=> !busy_o;
  endproperty
  a_nv_end: assert property (p_nv_end)
    else $error("write cycle overran its count");

  property p_nv_ignore;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (busy_o && wr_req_i && s_reg.cnt != '0) |=> s_reg.cnt == $past(s_reg.cnt) - CNT_W'(1);
  endproperty
  a_nv_ignore: assert property (p_nv_ignore)
    else $error("write during busy restarted the cycle");

endmodule

// ### bps_host_model.sv
// Host microcontroller model: serial master, analog source select.
// Assumes the supervisor samples all serial lines on ref_clk_i.
`timescale 1ns/1ps
module bps_host_model #(
  parameter int HALF_CYC = 4,
  parameter int SETTLE_CYC = 16
) (
  input wire logic ref_clk_i,
  input wire logic spi_so_i,
  input wire logic spi_so_oe_i,
  output bps_pkg::bps_spi_t spi_o,
  output logic [bps_pkg::SRC_W-1:0] src_o
);
  import bps_pkg::*;
  logic so_last = 1'b0;
  logic so_wire;
  logic [31:0] rx;

  // ==========================================================
  // Line level
  // No pull on the line, so a released output reads inverted
  always @(posedge ref_clk_i) if (spi_so_oe_i) so_last <= spi_so_i;
  assign so_wire = spi_so_oe_i ? spi_so_i : ~so_last;

  initial begin
    spi_o = '0;
    src_o = '0;
  end

  // ==========================================================
  // Serial frames
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Clock and data low, chip select low only when en is set, while the supply wakes the part
  task automatic hold_low(input logic en);
    spi_o = '{sck: 1'b0, cs_b: ~en, si: 1'b0};
    wait_clk(HALF_CYC);
  endtask

  // Edges held several clocks so the sampler sees each level
  task automatic frame(input logic [31:0] tx, input int nbits);
    rx = '0;
    spi_o.cs_b = 1'b0;
    wait_clk(HALF_CYC);
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_o.si = tx[i];
      wait_clk(HALF_CYC);
      rx = {rx[30:0], so_wire};
      spi_o.sck = 1'b1;
      wait_clk(HALF_CYC);
      spi_o.sck = 1'b0;
    end
    wait_clk(HALF_CYC);
    spi_o.si = 1'b0;
    spi_o.cs_b = 1'b1;
    wait_clk(HALF_CYC);
  endtask

  task automatic command(input logic [7:0] op);
    frame({24'h0, op}, 8);
  endtask

  // Balance and gain changes only travel in this frame
  task automatic ctrl_write(input logic [15:0] v);
    frame({8'h00, OP_CTRL_WRITE, v}, 24);
    wait_clk(SETTLE_CYC);
  endtask

  task automatic select_src(input logic [SRC_W-1:0] s);
    src_o = s;
    wait_clk(SETTLE_CYC);
  endtask

  task automatic nv_write(input logic [8:0] a, input logic [7:0] d, input logic en);
    if (en) command(OP_WR_ENABLE);
    frame({OP_NV_WRITE, 7'h00, a, d}, 32);
  endtask

  task automatic nv_read(input logic [8:0] a, output logic [7:0] d);
    frame({OP_NV_READ, 7'h00, a, 8'h00}, 32);
    d = rx[7:0];
  endtask

  task automatic status(output logic [7:0] st);
    frame({16'h0, OP_STATUS_READ, 8'h00}, 16);
    st = rx[7:0];
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the supervisor with a host model.
// Assumes short scan and write-cycle counts set by parameter.
`timescale 1ns/1ps
module testbench;
  import bps_pkg::*;
  localparam int SCAN = 8;
  localparam int NV_WR = 600;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  bps_spi_t spi;
  logic so;
  logic so_oe;
  logic ov_en;
  logic uv_en;
  logic oc;
  logic load_rel;
  logic wake;
  logic ov_cmp;
  logic [SRC_W-1:0] src;
  logic [CELL_IDX_W-1:0] cell_sel;
  bps_drive_t drive;
  bps_mon_t mon;
  logic sleep;
  logic [7:0] st;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc++;
  // Only the second cell reads over-charged
  assign ov_cmp = ov_en && (cell_sel == 2'h1);

  bps_supervisor #(.SCAN_CYC(16'(SCAN)), .NV_WRITE_CYC(NV_WR)) dut (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b), .spi_i(spi), .spi_so_o(so),
    .spi_so_oe_o(so_oe), .cell_ov_cmp_i(ov_cmp), .cell_uv_cmp_i(uv_en),
    .overcurrent_i(oc), .load_release_i(load_rel), .wake_i(wake),
    .analog_select_inputs_i(src), .cell_sel_o(cell_sel), .drive_o(drive),
    .mon_o(mon), .sleep_o(sleep));

  bps_host_model host (
    .ref_clk_i(ref_clk), .spi_so_i(so), .spi_so_oe_i(so_oe), .spi_o(spi), .src_o(src));

  // ==========================================================
  // Helpers
  task automatic wclk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check({25'h0, drive}, {25'h0, 7'b1100001});
    check({31'h0, sleep}, 32'h0);
  endtask

  task automatic t_ctrl();
    for (int i = 0; i < 4; i++) begin
      host.ctrl_write({8'h00, 2'(i), 4'h1 << i, 2'b11});
      check({25'h0, drive}, {25'h0, 2'b00, 4'h1 << i, 1'b1});
      check({30'h0, mon.gain}, 32'(i));
    end
    host.ctrl_write(16'h0003);
    check({25'h0, drive}, {25'h0, 7'b0000001});
  endtask

  task automatic t_overcurrent();
    host.select_src(3'h5);
    check({29'h0, mon.src}, 32'h5);
    oc = 1'b1;
    wclk(1);
    check({31'h0, drive.discharge_drive_out}, 32'h1);
    check({31'h0, drive.charge_drive_load_sense}, 32'h0);
    oc = 1'b0;
    host.status(st);
    check({31'h0, st[ST_OC]}, 32'h1);
    check({28'h0, drive.cell_balance_drive}, 32'h0);
    load_rel = 1'b1;
    wclk(2);
    load_rel = 1'b0;
    wclk(1);
    check({31'h0, drive.discharge_drive_out}, 32'h0);
  endtask

  task automatic t_scan();
    int prev;
    int n;
    int i;
    prev = int'(cell_sel);
    n = 0;
    for (i = 0; i < 4 * SCAN; i++) begin
      wclk(1);
      if (int'(cell_sel) != prev) begin
        check({30'h0, cell_sel}, (prev == 2) ? 32'h0 : 32'(prev + 1));
        prev = int'(cell_sel);
        n++;
      end
    end
    check(32'(n >= 3), 32'h1);
    ov_en = 1'b1;
    for (i = 0; i < 3 * SCAN + 4 && drive.charge_drive_load_sense !== 1'b1; i++) wclk(1);
    check({31'h0, drive.charge_drive_load_sense}, 32'h1);
    check({31'h0, drive.discharge_drive_out}, 32'h0);
    host.status(st);
    check({31'h0, st[ST_OV]}, 32'h1);
    ov_en = 1'b0;
    for (i = 0; i < 3 * SCAN + 4 && drive.charge_drive_load_sense !== 1'b0; i++) wclk(1);
    check({31'h0, drive.charge_drive_load_sense}, 32'h0);
  endtask

  task automatic t_nv();
    int t0;
    host.nv_write(9'h1ff, 8'h5a, 1'b1);
    t0 = cyc;
    // Second write lands while the first cycle still runs
    host.nv_write(9'h1ff, 8'ha5, 1'b1);
    host.status(st);
    check({31'h0, st[ST_BUSY]}, 32'h1);
    for (int n = 0; n < 20 && st[ST_BUSY] !== 1'b0; n++) host.status(st);
    check(32'(cyc - t0 <= NV_WR + 200), 32'h1);
    host.nv_read(9'h1ff, st);
    check({24'h0, st}, 32'h5a);
    host.command(OP_WR_DISABLE);
    host.nv_write(9'h1ff, 8'h33, 1'b0);
    wclk(NV_WR);
    host.nv_read(9'h1ff, st);
    check({24'h0, st}, 32'h5a);
  endtask

  task automatic t_sleep();
    host.ctrl_write(16'h0003);
    uv_en = 1'b1;
    for (int i = 0; i < 3 * SCAN + 4 && sleep !== 1'b1; i++) wclk(1);
    wclk(1);
    uv_en = 1'b0;
    check({31'h0, sleep}, 32'h1);
    check({25'h0, drive}, {25'h0, 7'b1100000});
    host.ctrl_write(16'h003f);
    check({25'h0, drive}, {25'h0, 7'b1100000});
    host.hold_low(1'b1);
    wake = 1'b1;
    wclk(2);
    wake = 1'b0;
    host.hold_low(1'b0);
    check({31'h0, sleep}, 32'h0);
    check({25'h0, drive}, {25'h0, 7'b1100001});
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial begin
    ov_en = 1'b0;
    uv_en = 1'b0;
    oc = 1'b0;
    load_rel = 1'b0;
    wake = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    host.hold_low(1'b0);
    t_reset();
    t_ctrl();
    t_overcurrent();
    t_scan();
    t_nv();
    t_sleep();
    close_out();
  end

  // Whole run needs about 4600 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end
endmodule
